/* src/buck_mode_freq_ctrl.sv */
// Functional notes
// R1: straps sampled once after reset, then latched
// R2: strap pair picks 3.3/5.0/5.35/12.0 volts
// R3: light-load select high forces PWM always
// R4: enter low power after three qualified ticks
// R5: leave on overvoltage or compensation high 200ns
// R6: below 97% switch critical conduction, 600mA cap
// R7: at 103% stop switching until below 97%
// R8: frequency strap high gives internal 2.15 MHz
// R9: resistor setting spans 400 kHz to 2.4 MHz
// R10: too-short on-time skips the pulse; the code skips only in PWM mode, not in low-power switching
// R11: dither sweeps 0.95 to 1.05 of nominal
// R12: internal dithered frequency never below 1.8 MHz
// R13: triangle sweep at fsw/256 or fsw/128
// R14: soft-start strap high gives 0.7 ms soft-start
// R15: soft-start forces PWM, ignores light-load select
// R16: dither only while sync pin held high
// R17: comparator results synchronised on the clock
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "buck_ctrl_regs.svh"

module buck_mode_freq_ctrl #(
	parameter int unsigned SS_CYCLES = `SS_CYCLES  // internal soft-start length in clocks
) (
	input  wire logic        clk,
	input  wire logic        rst,
	// classic wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [3:0]  sel_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// straps and pins
	input  wire logic        voutSelectHi,
	input  wire logic        voutSelectLo,
	input  wire logic        lightLoadSelect,
	input  wire logic        freqSetStrap,
	input  wire logic        softStartStrap,
	input  wire logic        ssCapDone,
	input  wire logic        syncPin,
	// analogue comparator results
	input  wire logic        outAboveHigh,
	input  wire logic        outBelowLow,
	input  wire logic        overVoltage,
	input  wire logic        compBelowEntry,
	input  wire logic        compAboveExit,
	input  wire logic        onTimeShort,
	// power-stage commands
	output logic      [1:0]  voutCode,
	output logic             lowPowerOperation,
	output logic             critConduction,
	output logic             peakLimit600mA,
	output logic             switchPulse,
	output logic             switchingIdle,
	output logic             ditherActive
);

	// ----------------------------------------------------------------
	// input synchronisation
	// ----------------------------------------------------------------
	pin_sync_if pinBus ();   // raw and settled pin levels

	// R17 comparators synchronised
	assign pinBus.raw = {voutSelectHi, voutSelectLo, lightLoadSelect, freqSetStrap, softStartStrap,
		ssCapDone, syncPin, outAboveHigh, outBelowLow, overVoltage, compBelowEntry, compAboveExit,
		onTimeShort};

	pin_sync u_sync (
		.clk  (clk),
		.rst  (rst),
		.pins (pinBus.sync)
	);

	logic sVsHi, sVsLo, sLightLoad, sFreqInt, sSsInt, sSsCap, sSync;  // settled straps
	logic sAbove, sBelow, sOv, sCompLow, sCompHigh, sShortOn;         // settled comparators

	assign {sVsHi, sVsLo, sLightLoad, sFreqInt, sSsInt, sSsCap, sSync, sAbove, sBelow, sOv, sCompLow,
		sCompHigh, sShortOn} = pinBus.synced;

	// ----------------------------------------------------------------
	// strap latch and soft-start
	// ----------------------------------------------------------------
	logic [1:0]  settle_q,  settle_d;    // clocks since reset release
	logic        strapOk_q, strapOk_d;   // straps captured
	logic [1:0]  vout_q,    vout_d;      // latched output selection
	logic        ssInt_q,   ssInt_d;     // soft-start strap captured
	logic        freqInt_q, freqInt_d;   // frequency strap captured
	logic [31:0] ssCnt_q,   ssCnt_d;     // internal soft-start timer
	logic        ssDone_q,  ssDone_d;    // soft-start finished

	// straps are caught once the synchroniser has filled, never again
	always_comb begin
		settle_d  = settle_q;
		strapOk_d = strapOk_q;
		vout_d    = vout_q;
		ssInt_d   = ssInt_q;
		freqInt_d = freqInt_q;
		ssCnt_d   = ssCnt_q;
		ssDone_d  = ssDone_q;
		if (!strapOk_q) begin
			if (settle_q == `STRAP_SETTLE) begin
				// R1 one-shot latch
				strapOk_d = 1'b1;
				// R2 hi strap is msb
				vout_d    = {sVsHi, sVsLo};
				ssInt_d   = sSsInt;
				freqInt_d = sFreqInt;
			end else begin
				settle_d = settle_q + 2'd1;
			end
		end else if (!ssDone_q) begin
			if (ssInt_q) begin
				// R14 fixed internal ramp
				if (ssCnt_q >= SS_CYCLES - 1) begin
					ssDone_d = 1'b1;
				end else begin
					ssCnt_d = ssCnt_q + 32'd1;
				end
			end else begin
				// external capacitor ramp ends on its comparator
				ssDone_d = sSsCap;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			settle_q  <= 2'd0;
			strapOk_q <= 1'b0;
			vout_q    <= 2'd0;
			ssInt_q   <= 1'b0;
			freqInt_q <= 1'b0;
			ssCnt_q   <= 32'd0;
			ssDone_q  <= 1'b0;
		end else begin
			settle_q  <= settle_d;
			strapOk_q <= strapOk_d;
			vout_q    <= vout_d;
			ssInt_q   <= ssInt_d;
			freqInt_q <= freqInt_d;
			ssCnt_q   <= ssCnt_d;
			ssDone_q  <= ssDone_d;
		end
	end

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	logic        ack_q,    ack_d;     // one-cycle acknowledge
	logic [31:0] rdat_q,   rdat_d;    // read data
	logic [31:0] freqInc_q, freqInc_d; // resistor-set phase increment
	logic [31:0] ctrl_q,   ctrl_d;    // control word
	logic [31:0] status;              // live status word
	logic [31:0] wrVal;               // byte-merged write value
	logic        modeLp;              // in any low-power state
	logic        skipNow;             // pulse being skipped

	// ack comes one clock after the request; write lands at the next edge, as ack is taken
	always_comb begin
		ack_d     = cyc_i && stb_i && !ack_q;
		rdat_d    = rdat_q;
		freqInc_d = freqInc_q;
		ctrl_d    = ctrl_q;
		wrVal     = (adr_i == `REG_FREQ_INC_ADDR) ? freqInc_q : ctrl_q;
		for (int b = 0; b < 4; b++) begin
			if (sel_i[b]) begin
				wrVal[b*8 +: 8] = dat_i[b*8 +: 8];
			end
		end
		if (ack_d) begin
			case (adr_i)
				`REG_STATUS_ADDR:   rdat_d = status;
				`REG_FREQ_INC_ADDR: rdat_d = freqInc_q;
				`REG_CTRL_ADDR:     rdat_d = ctrl_q;
				default:            rdat_d = 32'h0000_0000;  // unmapped reads zero
			endcase
		end
		if (cyc_i && stb_i && we_i && ack_q) begin
			if (adr_i == `REG_FREQ_INC_ADDR) begin
				// R9 clamp to resistor range
				if (wrVal < `INC_RES_MIN) begin
					freqInc_d = `INC_RES_MIN;
				end else if (wrVal > `INC_RES_MAX) begin
					freqInc_d = `INC_RES_MAX;
				end else begin
					freqInc_d = wrVal;
				end
			end else if (adr_i == `REG_CTRL_ADDR) begin
				ctrl_d = {31'h0000_0000, wrVal[`CTRL_DITHER_ALLOW_BIT]};
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_q     <= 1'b0;
			rdat_q    <= 32'h0000_0000;
			freqInc_q <= `INC_INT;
			ctrl_q    <= `CTRL_RESET;
		end else begin
			ack_q     <= ack_d;
			rdat_q    <= rdat_d;
			freqInc_q <= freqInc_d;
			ctrl_q    <= ctrl_d;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = rdat_q;

	always_comb begin
		status                      = 32'h0000_0000;
		status[`ST_LOW_POWER_BIT]   = modeLp;
		status[`ST_SS_DONE_BIT]     = ssDone_q;
		status[`ST_VOUT_LSB +: 2]   = vout_q;
		status[`ST_DITHER_BIT]      = ditherActive;
		status[`ST_IDLE_BIT]        = switchingIdle;
		status[`ST_SKIP_BIT]        = skipNow;
		status[`ST_INT_FREQ_BIT]    = freqInt_q;
		status[`ST_STRAP_OK_BIT]    = strapOk_q;
	end

	// ----------------------------------------------------------------
	// switching oscillator with triangular dither
	// ----------------------------------------------------------------
	logic [31:0] phase_q, phase_d;     // phase accumulator
	logic [7:0]  tri_q,   tri_d;       // triangle position 0..128
	logic        up_q,    up_d;        // triangle direction
	logic [7:0]  syncHi_q, syncHi_d;   // clocks sync pin has been high
	logic        tick;                 // one switching period elapsed
	logic        ditherOn;             // dither allowed now
	logic [31:0] baseInc;              // nominal increment
	logic [31:0] effInc;               // increment after dither
	logic [7:0]  triStep;              // triangle step per period
	logic signed [63:0] dithDelta;     // signed dither offset

	always_comb begin
		// R8 internal or R9 resistor frequency
		baseInc  = freqInt_q ? `INC_INT : freqInc_q;
		// R16 dither needs sync held high
		ditherOn = (syncHi_q == `SYNC_HIGH_CYCLES) && ctrl_q[`CTRL_DITHER_ALLOW_BIT] && strapOk_q;
		// R13 fsw/256 internal, fsw/128 resistor
		triStep  = freqInt_q ? 8'd1 : 8'd2;
		// R11 plus or minus five percent
		dithDelta = ($signed({32'h0000_0000, baseInc}) * ($signed({8'h00, tri_q}) - `TRI_CENTRE)
			* `DITH_SCALE) >>> `DITH_SHIFT;
		effInc = ditherOn ? 32'(64'($signed({32'h0000_0000, baseInc}) + dithDelta)) : baseInc;
		// R12 floor at 1.8 MHz
		if (freqInt_q && effInc < `INC_MIN_DITH) begin
			effInc = `INC_MIN_DITH;
		end
		{tick, phase_d} = {1'b0, phase_q} + {1'b0, effInc};
		tri_d    = tri_q;
		up_d     = up_q;
		syncHi_d = !sSync ? 8'd0 : (syncHi_q == `SYNC_HIGH_CYCLES) ? syncHi_q : syncHi_q + 8'd1;
		if (!ditherOn) begin
			tri_d = 8'(`TRI_CENTRE);
			up_d  = 1'b1;
		end else if (tick) begin
			// R13 triangle sweep
			if (up_q) begin
				tri_d = tri_q + triStep;
				up_d  = (tri_q + triStep) < `TRI_TOP;
			end else begin
				tri_d = tri_q - triStep;
				up_d  = (tri_q - triStep) == 8'd0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_q  <= 32'h0000_0000;
			tri_q    <= 8'h40;
			up_q     <= 1'b1;
			syncHi_q <= 8'h00;
		end else begin
			phase_q  <= phase_d;
			tri_q    <= tri_d;
			up_q     <= up_d;
			syncHi_q <= syncHi_d;
		end
	end

	// ----------------------------------------------------------------
	// light-load mode state machine
	// ----------------------------------------------------------------
	buck_ctrl_pkg::mode_t mode_q, mode_d;   // operating state
	logic [1:0]  entry_q, entry_d;          // qualified switching ticks
	logic [7:0]  compHi_q, compHi_d;        // clocks compensation high
	logic        entryOk;                   // all entry conditions now
	logic        forcePwm;                  // pin or soft-start forces PWM
	logic        pulse_q, pulse_d;          // registered switch command
	logic        crit_q, crit_d;            // critical conduction command
	logic        idle_q, idle_d;            // switching stopped

	assign modeLp = (mode_q != buck_ctrl_pkg::MODE_PWM);

	always_comb begin
		// R3 pin high forces PWM; R15 soft-start too
		forcePwm = sLightLoad || !ssDone_q;
		// R4 four entry conditions
		entryOk  = ssDone_q && sAbove && !sOv && sCompLow;
		mode_d   = mode_q;
		entry_d  = entryOk ? entry_q : 2'd0;
		// R5 compensation hold counter
		compHi_d = sCompHigh ? ((compHi_q == 8'(`COMP_HOLD_CYCLES)) ? compHi_q : compHi_q + 8'd1) : 8'd0;
		case (mode_q)
			buck_ctrl_pkg::MODE_PWM: begin
				if (forcePwm) begin
					entry_d = 2'd0;
				end else if (entryOk && tick) begin
					// R4 third consecutive tick
					if (entry_q == `LP_ENTRY_TICKS - 2'd1) begin
						entry_d = 2'd0;
						mode_d  = buck_ctrl_pkg::MODE_LP_IDLE;
					end else begin
						entry_d = entry_q + 2'd1;
					end
				end
			end
			buck_ctrl_pkg::MODE_LP_SWITCH, buck_ctrl_pkg::MODE_LP_IDLE: begin
				entry_d = 2'd0;
				// R5 overvoltage or comp high
				if (forcePwm || sOv || compHi_q == 8'(`COMP_HOLD_CYCLES)) begin
					mode_d = buck_ctrl_pkg::MODE_PWM;
				end else if (sAbove) begin
					// R7 stop at upper threshold
					mode_d = buck_ctrl_pkg::MODE_LP_IDLE;
				end else if (sBelow) begin
					// R6 resume below lower threshold
					mode_d = buck_ctrl_pkg::MODE_LP_SWITCH;
				end
			end
			default: mode_d = buck_ctrl_pkg::MODE_PWM;
		endcase
		// R10 skip rather than shorten
		skipNow = (mode_q == buck_ctrl_pkg::MODE_PWM) && sShortOn;
		pulse_d = tick && strapOk_q && !skipNow && (mode_q != buck_ctrl_pkg::MODE_LP_IDLE);
		crit_d  = (mode_d == buck_ctrl_pkg::MODE_LP_SWITCH);
		idle_d  = (mode_d == buck_ctrl_pkg::MODE_LP_IDLE);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_q   <= buck_ctrl_pkg::MODE_PWM;
			entry_q  <= 2'd0;
			compHi_q <= 8'h00;
			pulse_q  <= 1'b0;
			crit_q   <= 1'b0;
			idle_q   <= 1'b0;
		end else begin
			mode_q   <= mode_d;
			entry_q  <= entry_d;
			compHi_q <= compHi_d;
			pulse_q  <= pulse_d;
			crit_q   <= crit_d;
			idle_q   <= idle_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs to the power stage
	// ----------------------------------------------------------------
	assign voutCode          = vout_q;
	assign lowPowerOperation = modeLp;
	assign critConduction    = crit_q;
	// R6 peak cap only in critical conduction
	assign peakLimit600mA    = crit_q;
	assign switchPulse       = pulse_q;
	assign switchingIdle     = idle_q;
	assign ditherActive      = (tri_q != 8'h40) || ditherOn;

endmodule // buck_mode_freq_ctrl

/* src/buck_ctrl_regs.svh */
`ifndef BUCK_CTRL_REGS_SVH
`define BUCK_CTRL_REGS_SVH

// --------------------------------------------------------------------
// register map (byte addresses, one 32-bit word each)
// --------------------------------------------------------------------
`define REG_STATUS_ADDR    8'h00
`define REG_FREQ_INC_ADDR  8'h04
`define REG_CTRL_ADDR      8'h08
`define REG_ADDR_BITS      8

// status register field positions
`define ST_LOW_POWER_BIT   0
`define ST_SS_DONE_BIT     1
`define ST_VOUT_LSB        2
`define ST_DITHER_BIT      4
`define ST_IDLE_BIT        5
`define ST_SKIP_BIT        6
`define ST_INT_FREQ_BIT    7
`define ST_STRAP_OK_BIT    8

// control register field positions and reset value
`define CTRL_DITHER_ALLOW_BIT 0
`define CTRL_RESET            32'h0000_0001

// --------------------------------------------------------------------
// clock and timing
// --------------------------------------------------------------------
`define CLK_HZ             64'd20000000
`define CLK_PERIOD_NS      50
`define SS_TIME_NS         700000
`define SS_CYCLES          ((`SS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COMP_HOLD_NS       200
`define COMP_HOLD_CYCLES   ((`COMP_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LP_ENTRY_TICKS     2'd3
`define STRAP_SETTLE       2'd3
`define SYNC_HIGH_CYCLES   8'd64

// --------------------------------------------------------------------
// switching frequency as phase increments of a 32-bit accumulator
// --------------------------------------------------------------------
`define FREQ_INT_HZ        64'd2150000
`define FREQ_MIN_DITH_HZ   64'd1800000
`define FREQ_RES_MIN_HZ    64'd400000
`define FREQ_RES_MAX_HZ    64'd2400000
`define HZ_TO_INC(f)       (((f) << 32) / `CLK_HZ)
`define HZ_TO_INC_UP(f)    ((((f) << 32) + `CLK_HZ - 64'd1) / `CLK_HZ)
`define INC_INT            32'(`HZ_TO_INC(`FREQ_INT_HZ))
`define INC_MIN_DITH       32'(`HZ_TO_INC_UP(`FREQ_MIN_DITH_HZ))
`define INC_RES_MIN        32'(`HZ_TO_INC_UP(`FREQ_RES_MIN_HZ))
`define INC_RES_MAX        32'(`HZ_TO_INC(`FREQ_RES_MAX_HZ))

// dither: triangle 0..128 around centre 64, +-5 percent at the ends
`define TRI_TOP            8'd128
`define TRI_CENTRE         16'sd64
`define DITH_SCALE         64'sd205
`define DITH_SHIFT         18

`endif

/* src/buck_ctrl_pkg.sv */
package buck_ctrl_pkg;

	// light-load operating state
	typedef enum logic [1:0] {
		MODE_PWM,
		MODE_LP_SWITCH,
		MODE_LP_IDLE
	} mode_t;

	// number of asynchronous inputs passed through the synchroniser
	localparam int unsigned PIN_COUNT = 13;

	typedef logic [PIN_COUNT-1:0] pin_vec_t;

endpackage

/* src/pin_sync_if.sv */
`timescale 1ns/1ns

// raw pins in, synchronised levels out
interface pin_sync_if;
	buck_ctrl_pkg::pin_vec_t raw;      // straight from the pins
	buck_ctrl_pkg::pin_vec_t synced;   // after two flops

	modport sync (input raw, output synced);
	modport user (output raw, input synced);
endinterface

/* src/pin_sync.sv */
`timescale 1ns/1ns

// --------------------------------------------------------------------
// two-flop synchroniser bank
// --------------------------------------------------------------------
module pin_sync (
	input  wire logic clk,
	input  wire logic rst,
	pin_sync_if.sync  pins
);

	buck_ctrl_pkg::pin_vec_t firstQ;   // metastable stage, read only by secondQ
	buck_ctrl_pkg::pin_vec_t secondQ;  // settled stage

	// both stages clear to zero so straps read low until sampled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			firstQ  <= '0;
			secondQ <= '0;
		end else begin
			firstQ  <= pins.raw;
			secondQ <= firstQ;
		end
	end

	assign pins.synced = secondQ;

endmodule // pin_sync

/* verification/buck_ctrl_checker_asserts.sv */
`timescale 1ns/1ns
// ----------------------------------------
// bus timing and mode checks at the ports
// ----------------------------------------
module buck_ctrl_checker (
	input logic       clk,
	input logic       rst,
	input logic       cyc_i,
	input logic       stb_i,
	input logic       ack_o,
	input logic [1:0] voutCode,
	input logic       lightLoadSelect,
	input logic       overVoltage,
	input logic       compBelowEntry,
	input logic       compAboveExit,
	input logic       outAboveHigh,
	input logic       onTimeShort,
	input logic       lowPowerOperation,
	input logic       critConduction,
	input logic       peakLimit600mA,
	input logic       switchPulse,
	input logic       switchingIdle
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [3:0] relCnt_q;  // clocks since reset, saturating
	logic [5:0] qualCnt_q; // clocks the entry levels held at the pins
	wire        qual = compBelowEntry && outAboveHigh && !overVoltage && !lightLoadSelect;
	// counters only; raw pins lead the synchronised view by two clocks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			relCnt_q  <= 4'h0;
			qualCnt_q <= 6'h00;
		end else begin
			relCnt_q  <= relCnt_q + {3'h0, relCnt_q != 4'hF};
			qualCnt_q <= qual ? qualCnt_q + {5'h00, qualCnt_q != 6'h3F} : 6'h00;
		end
	end
	ack_late_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
	ack_wide_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
	vout_held_a: assert property (relCnt_q == 4'hF |-> $stable(voutCode)) else $error("code moved");
	pwm_forced_a: assert property (lightLoadSelect [*5] |-> !lowPowerOperation) else $error("forced mode lost");
	entry_hold_a: assert property ($rose(lowPowerOperation) |-> qualCnt_q >= 6'h10) else $error("early entry");
	ov_exit_a: assert property (overVoltage [*5] |-> !lowPowerOperation) else $error("no exit on ov");
	comp_exit_a: assert property (compAboveExit [*8] |-> !lowPowerOperation) else $error("no exit on comp");
	peak_cap_a: assert property (critConduction == peakLimit600mA && !(critConduction && switchingIdle))
		else $error("peak cap wrong");
	idle_quiet_a: assert property (switchingIdle && $past(switchingIdle) |-> !switchPulse) else $error("idle pulse");
	// a pulse launched in the last low-power cycle is not a skip failure, so both cycles must be PWM
	skip_pulse_a: assert property (onTimeShort [*5] ##0 !(lowPowerOperation || $past(lowPowerOperation))
		|-> !switchPulse) else $error("short pulse");
	cover property ($rose(lowPowerOperation));
	cover property (critConduction && switchPulse);
	cover property (switchingIdle ##1 !lowPowerOperation);
endmodule // buck_ctrl_checker

bind buck_mode_freq_ctrl buck_ctrl_checker chk_u (.clk, .rst, .cyc_i, .stb_i, .ack_o, .voutCode, .lightLoadSelect,
	.overVoltage, .compBelowEntry, .compAboveExit, .outAboveHigh, .onTimeShort, .lowPowerOperation,
	.critConduction, .peakLimit600mA, .switchPulse, .switchingIdle);

/* verification/buck_pin_plant.sv */
`timescale 1ns/1ns
// ----------------------------------------
// straps and comparator levels of the analogue side
// ----------------------------------------
module buck_pin_plant (
	input  logic clk,
	output logic voutSelectHi,
	output logic voutSelectLo,
	output logic lightLoadSelect,
	output logic freqSetStrap,
	output logic softStartStrap,
	output logic ssCapDone,
	output logic syncPin,
	output logic outAboveHigh,
	output logic outBelowLow,
	output logic overVoltage,
	output logic compBelowEntry,
	output logic compAboveExit,
	output logic onTimeShort
);
	logic [12:0] pins = 13'h0000; // straps 12..6, comparators 5..0
	assign {voutSelectHi, voutSelectLo, lightLoadSelect, freqSetStrap, softStartStrap, ssCapDone, syncPin,
		outAboveHigh, outBelowLow, overVoltage, compBelowEntry, compAboveExit, onTimeShort} = pins;
	// levels move only just after an edge, never mid-cycle
	task automatic put(input logic [12:0] v);
		@(posedge clk);
		pins <= v;
	endtask
endmodule // buck_pin_plant

/* verification/test_buck_mode_freq_ctrl.sv */
`timescale 1ns/1ns
`include "buck_ctrl_regs.svh"
// ----------------------------------------
// bus and pin driven checks
// ----------------------------------------
module test_buck_mode_freq_ctrl;
	localparam int unsigned SS_N = 40; // short soft-start keeps the run brief
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_o, rd;
	logic [1:0]  voutCode;
	logic        ack_o, lowPowerOperation, critConduction, peakLimit600mA, switchPulse, switchingIdle, ditherActive;
	logic        voutSelectHi, voutSelectLo, lightLoadSelect, freqSetStrap, softStartStrap, ssCapDone, syncPin;
	logic        outAboveHigh, outBelowLow, overVoltage, compBelowEntry, compAboveExit, onTimeShort;
	logic [12:0] pv = 13'h0000; // pin word handed to the plant
	int          miscompares = 0, cmpCount = 0, cycles = 0, cnt, mn, mx;
	buck_mode_freq_ctrl #(.SS_CYCLES(SS_N)) dut_u (.clk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i,
		.dat_o, .ack_o, .voutSelectHi, .voutSelectLo, .lightLoadSelect, .freqSetStrap, .softStartStrap,
		.ssCapDone, .syncPin, .outAboveHigh, .outBelowLow, .overVoltage, .compBelowEntry, .compAboveExit,
		.onTimeShort, .voutCode, .lowPowerOperation, .critConduction, .peakLimit600mA, .switchPulse,
		.switchingIdle, .ditherActive);
	buck_pin_plant plant_u (.clk, .voutSelectHi, .voutSelectLo, .lightLoadSelect, .freqSetStrap,
		.softStartStrap, .ssCapDone, .syncPin, .outAboveHigh, .outBelowLow, .overVoltage, .compBelowEntry,
		.compAboveExit, .onTimeShort);
	always #25 clk = ~clk;
	// hang guard: the tests need roughly 8400 clocks
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrapUp();
		end
	end
	task automatic wrapUp();
		$display("compares %0d mismatches %0d", cmpCount, miscompares);
		if (miscompares == 0 && cmpCount > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		cmpCount++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle, entered just after an edge; holds until ack is seen
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		do @(posedge clk); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk);
	endtask
	task automatic pin(input int b, input logic v);
		pv[b] = v;
		plant_u.put(pv);
	endtask
	task automatic rstWith(input logic [12:0] p);
		rst <= 1'b1;
		pv = p;
		plant_u.put(pv);
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	task automatic waitMode(input logic v);
		for (int n = 0; n < 300 && lowPowerOperation !== v; n++)
			@(posedge clk);
	endtask
	// pulse count and shortest and longest spacing over n clocks
	task automatic gaps(input int n);
		int last;
		last = -1;
		cnt = 0;
		mn = 999;
		mx = 0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			if (switchPulse === 1'b1) begin
				if (last >= 0 && i - last < mn)
					mn = i - last;
				if (last >= 0 && i - last > mx)
					mx = i - last;
				cnt++;
				last = i;
			end
		end
	endtask
	initial begin
		for (int c = 0; c < 4; c++) begin
			rstWith({c[1:0], 11'h700});
			chk({30'h0, voutCode}, c);
			pin(12, !c[1]);
			pin(11, !c[0]);
			repeat (6) @(posedge clk);
			chk({30'h0, voutCode}, c);
			wb(1'b0, `REG_STATUS_ADDR, 32'h0);
			chk(rd & 32'h18E, 32'h180 | (c << 2));
		end
		repeat (40) @(posedge clk);
		wb(1'b0, `REG_STATUS_ADDR, 32'h0);
		chkb(rd[1], 1'b1);
		$display("test straps done");
		wb(1'b0, `REG_CTRL_ADDR, 32'h0);
		chk(rd, `CTRL_RESET);
		wb(1'b0, `REG_FREQ_INC_ADDR, 32'h0);
		chk(rd, `INC_INT);
		wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
		wb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, `REG_FREQ_INC_ADDR, 32'h0);
		wb(1'b0, `REG_FREQ_INC_ADDR, 32'h0);
		chk(rd, `INC_RES_MIN);
		wb(1'b1, `REG_FREQ_INC_ADDR, 32'hFFFF_FFFF);
		wb(1'b0, `REG_FREQ_INC_ADDR, 32'h0);
		chk(rd, `INC_RES_MAX);
		$display("test registers done");
		gaps(1000);
		chkb(cnt >= 107 && cnt <= 108, 1'b1);
		chk(mn, 9);
		chkb(ditherActive, 1'b0);
		pin(6, 1'b1);
		repeat (80) @(posedge clk);
		chkb(ditherActive, 1'b1);
		gaps(5200);
		chk(mn, 8);
		chk(mx, 10);
		$display("test frequency done");
		rstWith(13'h0024);
		wb(1'b1, `REG_FREQ_INC_ADDR, 32'h0);
		gaps(1000);
		chkb(cnt >= 20 && cnt <= 21, 1'b1);
		chkb(lowPowerOperation, 1'b0);
		wb(1'b1, `REG_FREQ_INC_ADDR, `INC_INT);
		pin(7, 1'b1);
		waitMode(1'b1);
		chk({30'h0, lowPowerOperation, switchingIdle}, 32'h3);
		pin(5, 1'b0);
		pin(4, 1'b1);
		repeat (5) @(posedge clk);
		chk({30'h0, critConduction, peakLimit600mA}, 32'h3);
		gaps(100);
		chkb(cnt > 0, 1'b1);
		pin(5, 1'b1);
		pin(4, 1'b0);
		repeat (5) @(posedge clk);
		gaps(100);
		chk({31'h0, switchingIdle}, 32'h1);
		chk(cnt, 0);
		pin(1, 1'b1);
		pin(1, 1'b0);
		repeat (10) @(posedge clk);
		chkb(lowPowerOperation, 1'b1);
		pin(1, 1'b1);
		repeat (3) @(posedge clk);
		chkb(lowPowerOperation, 1'b1);
		repeat (6) @(posedge clk);
		chkb(lowPowerOperation, 1'b0);
		pin(1, 1'b0);
		waitMode(1'b1);
		chkb(lowPowerOperation, 1'b1);
		pin(3, 1'b1);
		repeat (5) @(posedge clk);
		chkb(lowPowerOperation, 1'b0);
		pin(3, 1'b0);
		waitMode(1'b1);
		chkb(lowPowerOperation, 1'b1);
		pin(10, 1'b1);
		repeat (300) @(posedge clk);
		chkb(lowPowerOperation, 1'b0);
		$display("test mode exits done");
		pin(0, 1'b1);
		repeat (3) @(posedge clk);
		gaps(100);
		chk(cnt, 0);
		pin(0, 1'b0);
		gaps(100);
		chkb(cnt > 0, 1'b1);
		$display("test pulse skip done");
		wrapUp();
	end
endmodule // test_buck_mode_freq_ctrl
